// file: ctpg_fifo.sv
`timescale 1ns/1ps
module ctpg_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	// Fill level
	output logic [$clog2(DEPTH):0] level_o
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	// Handshakes
	assign in_ready_o = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign level_o = count;
	assign out_data_o = mem[rd_ptr];

	// Storage
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// Pointers and count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end

endmodule

// file: ctpg_lab.sv
`timescale 1ns/1ps
module ctpg_lab (
	// Clock
	input wire logic clk_i,
	// Position transmitter under measurement
	input wire logic ais_rf_on_o,
	input wire logic ais_bit_o,
	// Decoder verdict pulses
	output logic ack_good_o,
	output logic ack_bad_o
);
	logic cap[0:127];
	// Decoder quiet at start
	initial begin
		ack_good_o = 1'b0;
		ack_bad_o = 1'b0;
	end
	// Burst of identical acknowledgements, wrong ones first
	task automatic send_acks(input int good, input int bad);
		for (int i = 0; i < good + bad; i++) begin
			@(posedge clk_i);
			ack_good_o <= (i >= bad);
			ack_bad_o <= (i < bad);
			@(posedge clk_i);
			ack_good_o <= 1'b0;
			ack_bad_o <= 1'b0;
		end
	endtask
	// Wait out any frame, then record the next one mid-bit
	task automatic capture(input int n, input int per, output bit ok);
		int t;
		t = 0;
		@(negedge clk_i);
		while (ais_rf_on_o && t < 4000) begin
			@(negedge clk_i);
			t++;
		end
		while (!ais_rf_on_o && t < 4000) begin
			@(negedge clk_i);
			t++;
		end
		ok = (t < 4000);
		repeat (per / 2) @(negedge clk_i);
		for (int i = 0; i < n; i++) begin
			cap[i] = ais_bit_o;
			repeat (per) @(negedge clk_i);
		end
	endtask
endmodule

// file: ctpg_monitor.sv
`timescale 1ns/1ps
module ctpg_monitor #(
	parameter int AIS_BAUD_CYC = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus handshake
	input wire logic wb_stb_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic wb_ack_o,
	// Position transmitter
	input wire logic ais_rf_on_o,
	input wire logic ais_ramp_up_o,
	input wire logic ais_ramp_down_o,
	input wire logic ais_bit_o,
	input wire logic slot_reference_edge_o
);
	int slot_cnt;
	int ramp_cnt;
	logic slot_seen;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Cycles since the last slot edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slot_cnt <= 0;
			slot_seen <= 1'b0;
		end else if (slot_reference_edge_o) begin
			slot_cnt <= 1;
			slot_seen <= 1'b1;
		end else begin
			slot_cnt <= slot_cnt + 1;
		end
	end
	// Cycles spent in ramp-up
	always_ff @(posedge clk_i) begin
		if (rst_i || !ais_ramp_up_o) begin
			ramp_cnt <= 0;
		end else begin
			ramp_cnt <= ramp_cnt + 1;
		end
	end
	// Bus answers
	a_ack_one_cycle:
		assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_next_cycle:
		assert property (wb_stb_i && !wb_ack_o && wb_adr_i != 8'h10 |=> wb_ack_o)
			else $error("ack late");
	a_ack_needs_strobe:
		assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("ack unasked");
	// Slot timing and frame shape
	a_slot_period:
		assert property (slot_reference_edge_o && slot_seen |-> slot_cnt == 256 * AIS_BAUD_CYC)
			else $error("slot period wrong");
	a_frame_on_slot:
		assert property ($rose(ais_rf_on_o) |-> $past(slot_reference_edge_o) && ais_ramp_up_o)
			else $error("frame off slot");
	a_ramp_up_length:
		assert property ($fell(ais_ramp_up_o) |-> ramp_cnt == 8 * AIS_BAUD_CYC)
			else $error("ramp length wrong");
	a_ramp_in_frame:
		assert property (ais_ramp_up_o || ais_ramp_down_o |-> ais_rf_on_o && !ais_bit_o)
			else $error("ramp outside frame");
	a_frame_ramped_off:
		assert property ($fell(ais_rf_on_o) |-> $past(ais_ramp_down_o)) else $error("frame cut");
endmodule
bind ctpg_top ctpg_monitor #(.AIS_BAUD_CYC(AIS_BAUD_CYC)) ctpg_monitor_inst (
	.clk_i(clk_i), .rst_i(rst_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i),
	.wb_ack_o(wb_ack_o), .ais_rf_on_o(ais_rf_on_o), .ais_ramp_up_o(ais_ramp_up_o),
	.ais_ramp_down_o(ais_ramp_down_o), .ais_bit_o(ais_bit_o),
	.slot_reference_edge_o(slot_reference_edge_o));

// file: ctpg_pkg.sv
package ctpg_pkg;

	// ----------------------------------------------------------------
	// Clock and symbol timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 250_000_000;
	localparam int DSC_BAUD_HZ = 1200;
	localparam int AIS_BAUD_HZ = 9600;
	// Symbol periods rounded down to whole cycles
	localparam int DSC_BAUD_CYC = CLK_HZ / DSC_BAUD_HZ;
	localparam int AIS_BAUD_CYC = CLK_HZ / AIS_BAUD_HZ;
	localparam int DIV_W = 18;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_DSC_MODE = 8'h04;
	localparam logic [7:0] REG_AIS_MODE = 8'h08;
	localparam logic [7:0] REG_AIS_LEN = 8'h0C;
	localparam logic [7:0] REG_AIS_DATA = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_RX_COUNT = 8'h18;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_TEST_EN_BIT = 0;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_UNDERRUN_BIT = 1;
	localparam int ST_RX_PASS_BIT = 2;
	localparam int ST_RX_CLR_BIT = 3;
	localparam int ST_LEVEL_LSB = 8;
	localparam logic [4:0] AIS_LEN_RESET = 5'h15;

	// ----------------------------------------------------------------
	// Frame layout in bits
	// ----------------------------------------------------------------
	localparam logic [7:0] RAMP_BITS = 8'h08;
	localparam logic [7:0] HEADER_BITS = 8'h18;
	localparam logic [7:0] FLAG_BITS = 8'h08;
	localparam logic [7:0] CRC_BITS = 8'h10;
	localparam logic [7:0] SLOT_LAST = 8'hFF;
	localparam logic [7:0] FLAG_PATTERN = 8'h7E;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [8:0] PRBS_SEED = 9'h1FF;

	// ----------------------------------------------------------------
	// Receive acknowledgement criterion
	// ----------------------------------------------------------------
	localparam logic [3:0] ACK_TOTAL = 4'hA;
	localparam logic [3:0] ACK_PASS = 4'h8;

	// ----------------------------------------------------------------
	// Buffer shape
	// ----------------------------------------------------------------
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;

	// ----------------------------------------------------------------
	// Modes and states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		DSC_IDLE = 3'b000,
		DSC_HIGH = 3'b001,
		DSC_LOW = 3'b010,
		DSC_DOTS = 3'b011,
		DSC_PRBS = 3'b100,
		DSC_CARRIER = 3'b101
	} ctpg_dsc_mode_type;

	typedef enum logic [2:0] {
		AIS_IDLE = 3'b000,
		AIS_NORMAL = 3'b001,
		AIS_TEST1 = 3'b010,
		AIS_TEST2 = 3'b011,
		AIS_TEST3 = 3'b100,
		AIS_CARRIER = 3'b101
	} ctpg_ais_mode_type;

	typedef enum logic [2:0] {
		FR_IDLE = 3'b000,
		FR_RAMP_UP = 3'b001,
		FR_HEADER = 3'b010,
		FR_START_FLAG = 3'b011,
		FR_DATA = 3'b100,
		FR_CRC = 3'b101,
		FR_END_FLAG = 3'b110,
		FR_RAMP_DOWN = 3'b111
	} ctpg_frame_state_type;

	typedef struct packed {
		logic test_en;
		ctpg_dsc_mode_type dsc;
		ctpg_ais_mode_type ais;
		logic [4:0] len;
	} ctpg_ctrl_type;

endpackage

// file: ctpg_top.sv
// Functional notes
// R1: Alerting test can hold the modulator steadily on high tone or low tone.
// R2: Alerting test can send continuous alternating high/low dot pattern.
// R3: Alerting test can send repeating 511-bit pseudo-random tone sequence.
// R4: Pseudo-random source is nine-stage shift register, taps five and nine.
// R5: Alerting path can request an unmodulated carrier for testing.
// R6: Position test signal one fills whole frame with 0101 reversals.
// R7: Test signal one is sent without NRZI, bits unchanged on air.
// R8: Test signal two repeats 00001111 over whole frame, no NRZI.
// R9: Test signal three carries pseudo-random data in a framed message, no NRZI.
// R10: NRZI applies to normal frames; bypass only while a test signal runs.
// R11: Transmitter power ramps up before and down after each frame; a frame cut by idle or carrier mode skips the ramp-down.
// R12: Position path can request an unmodulated carrier for testing.
// R13: A one-cycle slot reference edge marks each slot timing instant.
// R14: Receive tones come from outside equipment at 1200 baud.
// R15: Outside equipment sends at least ten identical test acknowledgements.
// R16: Receive check passes when eight of ten acknowledgements decode correctly.
// R17: Normal mode sends software-loaded position frames for outside capture.
// R18: One mode per path at a time; leaving test mode returns to idle; the position path keeps normal mode.
`timescale 1ns/1ps
module ctpg_top #(
	parameter int DSC_BAUD_CYC = ctpg_pkg::DSC_BAUD_CYC,
	parameter int AIS_BAUD_CYC = ctpg_pkg::AIS_BAUD_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Alerting transmitter
	output logic dsc_tx_en_o,
	output logic dsc_tone_high_o,
	output logic dsc_carrier_o,
	// Alerting receiver decoder results
	input wire logic dsc_rx_ack_good_i,
	input wire logic dsc_rx_ack_bad_i,
	// Position-reporting transmitter
	output logic ais_rf_on_o,
	output logic ais_ramp_up_o,
	output logic ais_ramp_down_o,
	output logic ais_bit_o,
	output logic ais_carrier_o,
	output logic slot_reference_edge_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	ctpg_pkg::ctpg_ctrl_type ctrl;
	ctpg_pkg::ctpg_frame_state_type state;
	logic [ctpg_pkg::DIV_W-1:0] dsc_div;
	logic [ctpg_pkg::DIV_W-1:0] ais_div;
	logic dsc_tick;
	logic ais_tick;
	logic [8:0] dsc_lfsr;
	logic [8:0] ais_lfsr;
	logic [7:0] slot_cnt;
	logic slot_now;
	logic [7:0] bit_cnt;
	logic [7:0] state_last;
	logic [2:0] pat_cnt;
	logic [15:0] crc;
	logic [7:0] data_byte;
	logic nrzi_level;
	logic raw_bit;
	logic line_bit;
	logic test_sig;
	logic frame_mode;
	logic load_byte;
	logic underrun;
	logic [3:0] ack_good;
	logic [3:0] ack_total;
	logic rx_pass;
	logic req;
	logic wr;
	logic data_wr;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic [3:0] fifo_level;
	logic [31:0] next_rdata;

	// Shift register step, taps at stages five and nine
	function automatic logic [8:0] prbs_step(input logic [8:0] s);
		prbs_step = {s[7:0], s[8] ^ s[4]}; // R4
	endfunction

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign data_wr = wr && (wb_adr_i == ctpg_pkg::REG_AIS_DATA);

	// Ack one cycle after request; data writes wait for buffer room
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req && (!data_wr || fifo_in_ready);
		end
	end

	// Control registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl.test_en <= 1'b0;
			ctrl.dsc <= ctpg_pkg::DSC_IDLE;
			ctrl.ais <= ctpg_pkg::AIS_IDLE;
			ctrl.len <= ctpg_pkg::AIS_LEN_RESET;
		end else if (wr) begin
			case (wb_adr_i)
				ctpg_pkg::REG_CTRL: begin
					ctrl.test_en <= wb_dat_i[ctpg_pkg::CTRL_TEST_EN_BIT];
					// Leaving test mode drops every test pattern
					if (!wb_dat_i[ctpg_pkg::CTRL_TEST_EN_BIT]) begin
						ctrl.dsc <= ctpg_pkg::DSC_IDLE; // R18
						if (ctrl.ais != ctpg_pkg::AIS_NORMAL) begin
							ctrl.ais <= ctpg_pkg::AIS_IDLE; // R18
						end
					end
				end
				ctpg_pkg::REG_DSC_MODE: begin
					// One encoded mode; test patterns need test mode
					if (ctrl.test_en && wb_dat_i[2:0] <= ctpg_pkg::DSC_CARRIER) begin
						ctrl.dsc <= ctpg_pkg::ctpg_dsc_mode_type'(wb_dat_i[2:0]); // R18
					end else begin
						ctrl.dsc <= ctpg_pkg::DSC_IDLE;
					end
				end
				ctpg_pkg::REG_AIS_MODE: begin
					if (wb_dat_i[2:0] == ctpg_pkg::AIS_NORMAL) begin
						ctrl.ais <= ctpg_pkg::AIS_NORMAL; // R17
					end else if (ctrl.test_en && wb_dat_i[2:0] <= ctpg_pkg::AIS_CARRIER) begin
						ctrl.ais <= ctpg_pkg::ctpg_ais_mode_type'(wb_dat_i[2:0]); // R18
					end else begin
						ctrl.ais <= ctpg_pkg::AIS_IDLE;
					end
				end
				ctpg_pkg::REG_AIS_LEN: begin
					ctrl.len <= wb_dat_i[4:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Read mux
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (wb_adr_i)
			ctpg_pkg::REG_CTRL: next_rdata[0] = ctrl.test_en;
			ctpg_pkg::REG_DSC_MODE: next_rdata[2:0] = ctrl.dsc;
			ctpg_pkg::REG_AIS_MODE: next_rdata[2:0] = ctrl.ais;
			ctpg_pkg::REG_AIS_LEN: next_rdata[4:0] = ctrl.len;
			ctpg_pkg::REG_STATUS: begin
				next_rdata[ctpg_pkg::ST_BUSY_BIT] = (state != ctpg_pkg::FR_IDLE);
				next_rdata[ctpg_pkg::ST_UNDERRUN_BIT] = underrun;
				next_rdata[ctpg_pkg::ST_RX_PASS_BIT] = rx_pass;
				next_rdata[ctpg_pkg::ST_LEVEL_LSB +: 4] = fifo_level;
			end
			ctpg_pkg::REG_RX_COUNT: next_rdata[11:0] = {4'h0, ack_total, ack_good};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// Registered read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req && !wb_we_i) begin
			wb_dat_o <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Frame data buffer
	// ----------------------------------------------------------------
	ctpg_fifo #(
		.WIDTH(ctpg_pkg::FIFO_WIDTH),
		.DEPTH(ctpg_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(data_wr),
		.in_ready_o(fifo_in_ready),
		.in_data_i(wb_dat_i[7:0]),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(load_byte),
		.out_data_o(fifo_out_data),
		.level_o(fifo_level)
	);

	// ----------------------------------------------------------------
	// Alerting path
	// ----------------------------------------------------------------
	assign dsc_tick = (dsc_div == ctpg_pkg::DIV_W'(DSC_BAUD_CYC - 1));

	// Symbol rate divider
	always_ff @(posedge clk_i) begin
		if (rst_i || dsc_tick) begin
			dsc_div <= '0;
		end else begin
			dsc_div <= dsc_div + 1'b1;
		end
	end

	// Tone selection per symbol
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dsc_tone_high_o <= 1'b0;
			dsc_tx_en_o <= 1'b0;
			dsc_carrier_o <= 1'b0;
			dsc_lfsr <= ctpg_pkg::PRBS_SEED;
		end else begin
			dsc_tx_en_o <= (ctrl.dsc != ctpg_pkg::DSC_IDLE);
			dsc_carrier_o <= (ctrl.dsc == ctpg_pkg::DSC_CARRIER); // R5
			if (ctrl.dsc != ctpg_pkg::DSC_PRBS) begin
				dsc_lfsr <= ctpg_pkg::PRBS_SEED;
			end
			case (ctrl.dsc)
				ctpg_pkg::DSC_HIGH: dsc_tone_high_o <= 1'b1; // R1
				ctpg_pkg::DSC_LOW: dsc_tone_high_o <= 1'b0; // R1
				ctpg_pkg::DSC_DOTS: begin
					if (dsc_tick) begin
						dsc_tone_high_o <= !dsc_tone_high_o; // R2
					end
				end
				ctpg_pkg::DSC_PRBS: begin
					if (dsc_tick) begin
						dsc_tone_high_o <= dsc_lfsr[8]; // R3
						dsc_lfsr <= prbs_step(dsc_lfsr); // R4
					end
				end
				default: dsc_tone_high_o <= 1'b0;
			endcase
		end
	end

	// Acknowledgement tally, a clear keeps a new result from the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_good <= 4'h0;
			ack_total <= 4'h0;
		end else begin
			if (wr && wb_adr_i == ctpg_pkg::REG_STATUS && wb_dat_i[ctpg_pkg::ST_RX_CLR_BIT]) begin
				ack_total <= {3'h0, dsc_rx_ack_good_i || dsc_rx_ack_bad_i};
				ack_good <= {3'h0, dsc_rx_ack_good_i};
			end else if (ack_total != ctpg_pkg::ACK_TOTAL) begin
				if (dsc_rx_ack_good_i || dsc_rx_ack_bad_i) begin
					ack_total <= ack_total + 1'b1; // R15
				end
				if (dsc_rx_ack_good_i) begin
					ack_good <= ack_good + 1'b1;
				end
			end
		end
	end

	assign rx_pass = (ack_total == ctpg_pkg::ACK_TOTAL) && (ack_good >= ctpg_pkg::ACK_PASS); // R16

	// ----------------------------------------------------------------
	// Position-reporting path
	// ----------------------------------------------------------------
	assign ais_tick = (ais_div == ctpg_pkg::DIV_W'(AIS_BAUD_CYC - 1));
	assign slot_now = ais_tick && (slot_cnt == ctpg_pkg::SLOT_LAST);
	assign test_sig = (ctrl.ais == ctpg_pkg::AIS_TEST1) || (ctrl.ais == ctpg_pkg::AIS_TEST2)
		|| (ctrl.ais == ctpg_pkg::AIS_TEST3);
	assign frame_mode = test_sig || (ctrl.ais == ctpg_pkg::AIS_NORMAL && fifo_out_valid);

	// Bit rate divider and slot counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ais_div <= '0;
			slot_cnt <= 8'h00;
			slot_reference_edge_o <= 1'b0;
		end else begin
			ais_div <= ais_tick ? '0 : ais_div + 1'b1;
			if (ais_tick) begin
				slot_cnt <= slot_cnt + 1'b1;
			end
			slot_reference_edge_o <= slot_now; // R13
		end
	end

	// Length of the current frame section
	always_comb begin
		case (state)
			ctpg_pkg::FR_RAMP_UP: state_last = ctpg_pkg::RAMP_BITS - 8'h01;
			ctpg_pkg::FR_HEADER: state_last = ctpg_pkg::HEADER_BITS - 8'h01;
			ctpg_pkg::FR_DATA: state_last = {ctrl.len, 3'b000} - 8'h01;
			ctpg_pkg::FR_CRC: state_last = ctpg_pkg::CRC_BITS - 8'h01;
			ctpg_pkg::FR_RAMP_DOWN: state_last = ctpg_pkg::RAMP_BITS - 8'h01;
			default: state_last = ctpg_pkg::FLAG_BITS - 8'h01;
		endcase
	end

	// Raw bit before line coding
	always_comb begin
		case (state)
			ctpg_pkg::FR_HEADER: raw_bit = pat_cnt[0];
			ctpg_pkg::FR_DATA: begin
				raw_bit = (ctrl.ais == ctpg_pkg::AIS_TEST3) ? ais_lfsr[8] // R9
					: data_byte[bit_cnt[2:0]];
			end
			ctpg_pkg::FR_CRC: raw_bit = !crc[15];
			default: raw_bit = ctpg_pkg::FLAG_PATTERN[bit_cnt[2:0]];
		endcase
		if (ctrl.ais == ctpg_pkg::AIS_TEST1) begin
			raw_bit = pat_cnt[0]; // R6
		end else if (ctrl.ais == ctpg_pkg::AIS_TEST2) begin
			raw_bit = pat_cnt[2]; // R8
		end
		// Tests go out unaltered, normal frames NRZI coded
		line_bit = test_sig ? raw_bit : (raw_bit ? nrzi_level : !nrzi_level); // R7 R10
	end

	// Fetch next payload byte at each byte boundary
	assign load_byte = ais_tick && (ctrl.ais == ctpg_pkg::AIS_NORMAL) && (bit_cnt[2:0] == 3'h7)
		&& ((state == ctpg_pkg::FR_START_FLAG)
		|| (state == ctpg_pkg::FR_DATA && bit_cnt != state_last)); // R17

	// Frame sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ctpg_pkg::FR_IDLE;
			bit_cnt <= 8'h00;
		end else if (ais_tick) begin
			if (state == ctpg_pkg::FR_IDLE) begin
				if (slot_now && frame_mode) begin
					state <= ctpg_pkg::FR_RAMP_UP; // R11
				end
				bit_cnt <= 8'h00;
			end else if (ctrl.ais == ctpg_pkg::AIS_IDLE || ctrl.ais == ctpg_pkg::AIS_CARRIER) begin
				state <= ctpg_pkg::FR_IDLE; // R18
				bit_cnt <= 8'h00;
			end else if (bit_cnt == state_last) begin
				bit_cnt <= 8'h00;
				case (state)
					ctpg_pkg::FR_RAMP_UP: state <= ctpg_pkg::FR_HEADER;
					ctpg_pkg::FR_HEADER: state <= ctpg_pkg::FR_START_FLAG;
					ctpg_pkg::FR_START_FLAG: state <= ctpg_pkg::FR_DATA;
					ctpg_pkg::FR_DATA: state <= ctpg_pkg::FR_CRC;
					ctpg_pkg::FR_CRC: state <= ctpg_pkg::FR_END_FLAG;
					ctpg_pkg::FR_END_FLAG: state <= ctpg_pkg::FR_RAMP_DOWN; // R11
					default: state <= ctpg_pkg::FR_IDLE;
				endcase
			end else begin
				bit_cnt <= bit_cnt + 1'b1;
			end
		end
	end

	// Bit generators, checksum and line coding
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pat_cnt <= 3'h0;
			ais_lfsr <= ctpg_pkg::PRBS_SEED;
			crc <= ctpg_pkg::CRC_INIT;
			nrzi_level <= 1'b0;
		end else if (ais_tick) begin
			if (state == ctpg_pkg::FR_IDLE || state == ctpg_pkg::FR_RAMP_UP) begin
				pat_cnt <= 3'h0;
				ais_lfsr <= ctpg_pkg::PRBS_SEED;
				crc <= ctpg_pkg::CRC_INIT;
			end else if (state != ctpg_pkg::FR_RAMP_DOWN) begin
				pat_cnt <= pat_cnt + 1'b1;
				nrzi_level <= line_bit;
				if (state == ctpg_pkg::FR_DATA) begin
					if (ctrl.ais == ctpg_pkg::AIS_TEST3) begin
						ais_lfsr <= prbs_step(ais_lfsr); // R9
					end
					crc <= {crc[14:0], 1'b0} ^ ((crc[15] ^ raw_bit) ? ctpg_pkg::CRC_POLY : 16'h0000);
				end else if (state == ctpg_pkg::FR_CRC) begin
					crc <= {crc[14:0], 1'b1};
				end
			end
		end
	end

	// Payload byte and underrun flag, set wins over clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_byte <= 8'h00;
			underrun <= 1'b0;
		end else begin
			if (load_byte) begin
				data_byte <= fifo_out_valid ? fifo_out_data : 8'h00;
			end
			if (load_byte && !fifo_out_valid) begin
				underrun <= 1'b1;
			end else if (wr && wb_adr_i == ctpg_pkg::REG_STATUS
				&& wb_dat_i[ctpg_pkg::ST_UNDERRUN_BIT]) begin
				underrun <= 1'b0;
			end
		end
	end

	// Transmitter control levels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ais_rf_on_o <= 1'b0;
			ais_ramp_up_o <= 1'b0;
			ais_ramp_down_o <= 1'b0;
			ais_carrier_o <= 1'b0;
			ais_bit_o <= 1'b0;
		end else begin
			// Bit lines up with the ramp levels, silent while ramping
			ais_bit_o <= line_bit && (state != ctpg_pkg::FR_IDLE)
				&& (state != ctpg_pkg::FR_RAMP_UP) && (state != ctpg_pkg::FR_RAMP_DOWN); // R11
			ais_rf_on_o <= (state != ctpg_pkg::FR_IDLE);
			ais_ramp_up_o <= (state == ctpg_pkg::FR_RAMP_UP); // R11
			ais_ramp_down_o <= (state == ctpg_pkg::FR_RAMP_DOWN); // R11
			ais_carrier_o <= (ctrl.ais == ctpg_pkg::AIS_CARRIER); // R12
		end
	end

endmodule

// file: test_ctpg_top.sv
`timescale 1ns/1ps
module test_ctpg_top;
	localparam int BC = 4;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, rq;
	logic ack, tx_en, tone, dcar, abit, acar, rf_on, good, bad, prev;
	logic s[0:599];
	int errors = 0;
	int total_checks = 0;
	int r;
	bit ok;
	// Clock at 250 MHz
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	// Block and lab equipment
	ctpg_top #(.DSC_BAUD_CYC(BC), .AIS_BAUD_CYC(BC)) ctpg_top_inst (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.dsc_tx_en_o(tx_en), .dsc_tone_high_o(tone), .dsc_carrier_o(dcar),
		.dsc_rx_ack_good_i(good), .dsc_rx_ack_bad_i(bad), .ais_rf_on_o(rf_on),
		.ais_ramp_up_o(), .ais_ramp_down_o(), .ais_bit_o(abit), .ais_carrier_o(acar),
		.slot_reference_edge_o());
	ctpg_lab ctpg_lab_inst (.clk_i(clk_i), .ais_rf_on_o(rf_on), .ais_bit_o(abit),
		.ack_good_o(good), .ack_bad_o(bad));
	// Compare one result
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Counts, verdict, end of run
	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Classic single bus cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack !== 1'b1 && t < 3000);
		rq = rdat;
		if (t < 3000) begin
			cyc <= 1'b0;
			stb <= 1'b0;
		end else begin
			errors++;
			finish_test();
		end
	endtask
	// Read and compare
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		check(rq, e);
	endtask
	// Let registered outputs land
	task automatic settle;
		repeat (2) @(negedge clk_i);
	endtask
	// Expected raw frame bit; 2 marks an unpredicted bit
	function automatic int raw_bit(input int m, input int i);
		if (i < 8 || i > 71) return 0;
		if (m == 2) return (i - 8) % 2;
		if (m == 3) return ((i - 8) / 4) % 2;
		if (i < 32) return (i - 8) % 2;
		if (i < 40 || i > 63) return (8'h7E >> ((i - 32) % 8)) & 1;
		if (i < 48 && m == 1) return (8'hA5 >> (i - 40)) & 1;
		if (i < 48 && m == 4) return 1;
		return 2;
	endfunction
	// Main sequence
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int a = 0; a < 32; a += 4) begin
			rd(8'(a), (a == 12) ? 32'h15 : 32'h0);
		end
		wb(1'b1, 8'h04, 32'h1);
		rd(8'h04, 32'h0);
		wb(1'b1, 8'h00, 32'h1);
		for (int m = 1; m < 3; m++) begin
			wb(1'b1, 8'h04, m);
			settle();
			check({tx_en, tone, dcar}, {1'b1, m == 1, 1'b0});
		end
		wb(1'b1, 8'h04, 32'h5);
		settle();
		check({tx_en, dcar}, 2'b11);
		wb(1'b1, 8'h04, 32'h3);
		settle();
		for (int i = 0; i < 16; i++) begin
			prev = tone;
			repeat (BC) @(negedge clk_i);
			check(tone, !prev);
		end
		wb(1'b1, 8'h04, 32'h4);
		settle();
		for (int i = 0; i < 600; i++) begin
			s[i] = tone;
			repeat (BC) @(negedge clk_i);
		end
		for (int i = 9; i < 600; i++) begin
			check(s[i], s[i - 9] ^ s[i - 5]);
		end
		for (int i = 0; i < 89; i++) begin
			check(s[i], s[i + 511]);
		end
		wb(1'b1, 8'h00, 32'h0);
		settle();
		check(tx_en, 1'b0);
		rd(8'h04, 32'h0);
		// Framed test signals, one byte of data
		wb(1'b1, 8'h00, 32'h1);
		wb(1'b1, 8'h0C, 32'h1);
		for (int m = 2; m < 5; m++) begin
			wb(1'b1, 8'h08, m);
			ctpg_lab_inst.capture(80, BC, ok);
			check(ok, 1'b1);
			if (!ok) finish_test();
			for (int i = 0; i < 80; i++) begin
				r = raw_bit(m, i);
				if (r != 2) check(ctpg_lab_inst.cap[i], r);
			end
		end
		// Fill the buffer, then normal frames drain it
		wb(1'b1, 8'h08, 32'h0);
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, 8'h10, 32'hA5);
		end
		rd(8'h14, 32'h800);
		wb(1'b1, 8'h08, 32'h1);
		wb(1'b1, 8'h10, 32'hA5);
		ctpg_lab_inst.capture(80, BC, ok);
		check(ok, 1'b1);
		if (!ok) finish_test();
		for (int i = 9; i < 72; i++) begin
			r = raw_bit(1, i);
			if (r != 2 && i != 64) check(ctpg_lab_inst.cap[i] ^ ctpg_lab_inst.cap[i - 1], r == 0);
		end
		for (int k = 0; k < 40 && rq[11:8] != 4'h0; k++) begin
			repeat (300) @(posedge clk_i);
			wb(1'b0, 8'h14, 32'h0);
		end
		check(rq[11:8], 4'h0);
		// Receive tally, passing then failing
		ctpg_lab_inst.send_acks(8, 2);
		rd(8'h18, 32'hA8);
		wb(1'b0, 8'h14, 32'h0);
		check(rq[2], 1'b1);
		wb(1'b1, 8'h14, 32'h8);
		ctpg_lab_inst.send_acks(7, 3);
		rd(8'h18, 32'hA7);
		wb(1'b0, 8'h14, 32'h0);
		check(rq[2], 1'b0);
		// Carrier on the position path, dropped on exit
		repeat (400) @(posedge clk_i);
		wb(1'b1, 8'h08, 32'h5);
		settle();
		check(acar, 1'b1);
		wb(1'b1, 8'h00, 32'h0);
		settle();
		check(acar, 1'b0);
		rd(8'h08, 32'h0);
		finish_test();
	end
endmodule
